// ==== hdl/sdind_pkg.sv ====
// Purpose: Shared constants for the status indicator driver.
// Assumes: 200 MHz system clock, AHB-Lite register access.
// Notes:   Offsets are byte addresses of 32-bit registers.
package sdind_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 200_000_000;
    localparam int RUN_FLASH_HZ = 1;
    localparam int RUN_HALF_CYC = CLK_HZ / (2 * RUN_FLASH_HZ);
    localparam int BLINK_HZ = 4;
    localparam int BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
    localparam int FAULT_HIST_DEPTH = 10;

    // ------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_FAULT_LAST = 8'h08;
    localparam logic [7:0] ADDR_HIST_SEL = 8'h0C;
    localparam logic [7:0] ADDR_HIST_DATA = 8'h10;
    localparam logic [7:0] ADDR_HIST_COUNT = 8'h14;
    localparam int CTRL_DAD_BIT = 0;
    localparam int CTRL_RCLR_BIT = 1;
    localparam logic CTRL_DAD_RESET = 1'b0;
    localparam logic [3:0] HIST_SEL_RESET = 4'h0;
    localparam int ST_FAULT = 0;
    localparam int ST_RUN = 1;
    localparam int ST_SER = 2;
    localparam int ST_FORCE = 3;
    localparam int ST_CARD = 4;
    localparam int ST_NET = 5;
    localparam int ST_CSTATE = 6;
    localparam int ST_REC = 8;
    localparam int ST_NONREC = 9;
    localparam int FL_NONREC = 16;
    localparam int FL_VALID = 17;

    // ------------------------------------------------------------
    // Bus encodings and card states
    // ------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;
    typedef enum logic [1:0] {
        CARD_UNINIT,
        CARD_ERROR,
        CARD_IDLE,
        CARD_OPER
    } sdind_card_t;
endpackage

// ==== hdl/sdind_top.sv ====
// Purpose: Front-panel lamp driver with fault history and scan-paced
//          serial servicing, registers on AHB-Lite.
// Assumes: All status inputs are synchronous to hclk.
// Notes:   Zero-wait-state slave; every output is a flip-flop.
//
// Decided for this implementation: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - input lamp lit while its input is energized, dark when low
// - fault lamp dark, steady red non-recoverable, flashing recoverable
// - run lamp steady green while executing in run mode
// - run lamp flashes at 1 Hz in program mode or restore
// - serial lamp blinks only while transmitting, not on receive
// - serial lamp dark with no serial traffic
// - force lamp lit while any force active, dark otherwise
// - card lamp dark when absent, bad medium or bad file system
// - card lamp dark on access failure or config file errors
// - card lamp steady when initialized and not accessing
// - card lamp blinks while card is read or written
// - during restore card lamp blinks only in access intervals
// - network lamp dark without Ethernet link
// - network lamp flashes with link but no IP address
// - duplicate IP flashes network lamp only if detection enabled
// - network lamp steady with link and valid IP
// - output lamp follows its output's logic state
// - keep last fault brief plus ten newest non-recoverable records
// - each port's received requests serviced at most once per scan
// - master request issued only when instruction executes in scan
module sdind_top import sdind_pkg::*; #(
    parameter int NUM_IN = 12,
    parameter int NUM_OUT = 8,
    parameter int NUM_PORTS = 2,
    parameter int HIST_DEPTH = FAULT_HIST_DEPTH,
    parameter int RUN_HALF = RUN_HALF_CYC,
    parameter int BLINK_HALF = BLINK_HALF_CYC
) (
    input wire logic hclk, // System clock
    input wire logic hresetn, // Async reset, active low
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic [31:0] hrdata, // Read data
    output logic hreadyout, // Slave ready
    output logic hresp, // Response, always OKAY
    input wire logic [NUM_IN-1:0] in_term, // Input terminals
    input wire logic [NUM_OUT-1:0] out_state, // Output logic states
    input wire logic fault_event, // Fault occurs, one pulse
    input wire logic fault_nonrec, // Fault is non-recoverable
    input wire logic [15:0] fault_code, // Fault code
    input wire logic run_mode, // Run mode, else program
    input wire logic restore_busy, // Restore in progress
    input wire logic ser_tx_busy, // Serial transmit active
    input wire logic force_any, // Some force active
    input wire logic card_present, // Card inserted
    input wire logic card_medium_bad, // Card medium bad
    input wire logic card_fs_bad, // Card file system bad
    input wire logic card_rw_fail, // Card read or write failed
    input wire logic card_cfg_read_fail, // Startup file unreadable
    input wire logic card_cfg_error, // Startup file has errors
    input wire logic card_init_done, // Card fully initialized
    input wire logic card_access, // Card being read or written
    input wire logic eth_link, // Ethernet link up
    input wire logic ip_valid, // IP address held
    input wire logic ip_duplicate, // Duplicate IP seen
    input wire logic scan_tick, // Program scan boundary pulse
    input wire logic scan_active, // Program scan executing
    input wire logic [NUM_PORTS-1:0] port_rx_req, // Request received
    input wire logic [NUM_PORTS-1:0] msg_exec, // Master instr executes
    output logic [NUM_PORTS-1:0] port_service, // Service port, pulse
    output logic [NUM_PORTS-1:0] msg_issue, // Issue request, pulse
    output logic [NUM_IN-1:0] in_lamp, // Input lamps
    output logic [NUM_OUT-1:0] out_lamp, // Output lamps
    output logic fault_red, // Fault lamp
    output logic run_green, // Run lamp
    output logic ser_lamp, // Serial activity lamp
    output logic force_amber, // Force lamp
    output logic card_lamp, // Memory-card lamp
    output logic net_green // Network lamp
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    generate
        if (NUM_IN < 1 || NUM_OUT < 1 || NUM_PORTS < 1 ||
            HIST_DEPTH < 1 || HIST_DEPTH > 16 ||
            RUN_HALF < 1 || BLINK_HALF < 1) begin : g_bad
            $error("sdind_top: parameter out of range");
        end
    endgenerate

    logic [31:0] run_cnt;
    logic [31:0] blink_cnt;
    logic run_phase;
    logic blink_phase;
    logic dad_en;
    logic rec_fault;
    logic nonrec_fault;
    logic rec_clear;
    logic [15:0] last_code;
    logic last_nonrec;
    logic last_valid;
    logic [31:0] hist_mem [HIST_DEPTH];
    logic [3:0] wr_ptr;
    logic [4:0] hist_cnt;
    logic [3:0] hist_sel;
    logic [15:0] scan_cnt;
    logic [NUM_PORTS-1:0] pend;
    sdind_card_t card_state;
    sdind_card_t next_card_state;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic addr_ok;
    logic [31:0] status_word;
    logic [31:0] hist_word;
    logic [31:0] next_rdata;

    // ------------------------------------------------------------
    // Flash and blink generators
    // ------------------------------------------------------------
    // Free-running 1 Hz flash for the run lamp
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_cnt <= 32'h0000_0000;
            run_phase <= 1'b0;
        end else if (run_cnt == 32'(RUN_HALF - 1)) begin
            run_cnt <= 32'h0000_0000;
            run_phase <= ~run_phase;
        end else begin
            run_cnt <= run_cnt + 32'h0000_0001;
        end
    end

    // One shared blink keeps the fault, serial, card and network lamps in step
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            blink_cnt <= 32'h0000_0000;
            blink_phase <= 1'b0;
        end else if (blink_cnt == 32'(BLINK_HALF - 1)) begin
            blink_cnt <= 32'h0000_0000;
            blink_phase <= ~blink_phase;
        end else begin
            blink_cnt <= blink_cnt + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------
    // Fault latches and history
    // ------------------------------------------------------------
    // Non-recoverable sticks until reset; a new fault beats a clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rec_fault <= 1'b0;
            nonrec_fault <= 1'b0;
        end else begin
            if (fault_event && fault_nonrec) begin
                nonrec_fault <= 1'b1;
            end
            if (fault_event && !fault_nonrec) begin
                rec_fault <= 1'b1;
            end else if (rec_clear) begin
                rec_fault <= 1'b0;
            end
        end
    end

    // Brief record of whichever fault came last
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_code <= 16'h0000;
            last_nonrec <= 1'b0;
            last_valid <= 1'b0;
        end else if (fault_event) begin
            last_code <= fault_code;
            last_nonrec <= fault_nonrec;
            last_valid <= 1'b1;
        end
    end

    // Ring of detailed records; the oldest is overwritten first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ptr <= 4'h0;
            hist_cnt <= 5'h00;
        end else if (fault_event && fault_nonrec) begin
            wr_ptr <= (wr_ptr == 4'(HIST_DEPTH - 1)) ? 4'h0
                      : wr_ptr + 4'h1;
            if (hist_cnt != 5'(HIST_DEPTH)) begin
                hist_cnt <= hist_cnt + 5'h01;
            end
        end
    end

    // Memory has no reset; unused slots are masked by the count
    always_ff @(posedge hclk) begin
        if (fault_event && fault_nonrec) begin
            hist_mem[wr_ptr] <= {scan_cnt, fault_code};
        end
    end

    // Select 0 reads the newest record
    always_comb begin
        int idx;
        idx = int'(wr_ptr) - 1 - int'(hist_sel);
        if (idx < 0) begin
            idx = idx + HIST_DEPTH;
        end
        hist_word = 32'h0000_0000;
        if ({1'b0, hist_sel} < hist_cnt && idx >= 0) begin
            hist_word = hist_mem[idx[3:0]];
        end
    end

    // ------------------------------------------------------------
    // Scan-paced serial servicing
    // ------------------------------------------------------------
    // Scan count stamps the history records
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scan_cnt <= 16'h0000;
        end else if (scan_tick) begin
            scan_cnt <= scan_cnt + 16'h0001;
        end
    end

    // Requests wait for the next scan boundary; one service per scan
    generate
        for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    pend[p] <= 1'b0;
                    port_service[p] <= 1'b0;
                    msg_issue[p] <= 1'b0;
                end else begin
                    port_service[p] <= scan_tick && pend[p];
                    if (port_rx_req[p]) begin
                        pend[p] <= 1'b1;
                    end else if (scan_tick) begin
                        pend[p] <= 1'b0;
                    end
                    msg_issue[p] <= msg_exec[p] && scan_active;
                end
            end
            a_svc_scan: assert property (@(posedge hclk) disable iff (!hresetn)
                port_service[p] |-> $past(scan_tick)
                ##1 !port_service[p])
                else $error("port serviced off a scan boundary");
            a_msg_scan: assert property (@(posedge hclk) disable iff (!hresetn)
                msg_issue[p] |-> $past(msg_exec[p]) && $past(scan_active))
                else $error("master request outside its execution");
        end
    endgenerate

    // ------------------------------------------------------------
    // Lamp drive
    // ------------------------------------------------------------
    // Card state from its condition inputs, worst condition first
    always_comb begin
        if (!card_present || card_medium_bad || card_fs_bad) begin
            next_card_state = CARD_UNINIT;
        end else if (card_rw_fail || card_cfg_read_fail || card_cfg_error) begin
            next_card_state = CARD_ERROR;
        end else if (card_access) begin
            next_card_state = CARD_OPER;
        end else if (card_init_done) begin
            next_card_state = CARD_IDLE;
        end else begin
            next_card_state = CARD_UNINIT;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            card_state <= CARD_UNINIT;
        end else begin
            card_state <= next_card_state;
        end
    end

    // Lamps follow their sources one cycle late; card and fault lamps two cycles after their inputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in_lamp <= '0;
            out_lamp <= '0;
            fault_red <= 1'b0;
            run_green <= 1'b0;
            ser_lamp <= 1'b0;
            force_amber <= 1'b0;
            card_lamp <= 1'b0;
            net_green <= 1'b0;
        end else begin
            in_lamp <= in_term;
            out_lamp <= out_state;
            fault_red <= nonrec_fault || (rec_fault && blink_phase);
            run_green <= (run_mode && !restore_busy) || run_phase;
            ser_lamp <= ser_tx_busy && blink_phase;
            force_amber <= force_any;
            unique case (card_state)
                CARD_UNINIT: card_lamp <= 1'b0;
                CARD_ERROR: card_lamp <= 1'b0;
                CARD_IDLE: card_lamp <= 1'b1;
                CARD_OPER: card_lamp <= blink_phase;
            endcase
            if (!eth_link) begin
                net_green <= 1'b0;
            end else if (!ip_valid || (ip_duplicate && dad_en)) begin
                net_green <= blink_phase;
            end else begin
                net_green <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    assign addr_ok = hsel && htrans[1] && hready;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[ST_FAULT] = fault_red;
        status_word[ST_RUN] = run_green;
        status_word[ST_SER] = ser_lamp;
        status_word[ST_FORCE] = force_amber;
        status_word[ST_CARD] = card_lamp;
        status_word[ST_NET] = net_green;
        status_word[ST_CSTATE +: 2] = card_state;
        status_word[ST_REC] = rec_fault;
        status_word[ST_NONREC] = nonrec_fault;
    end

    // Read data is fetched in the address phase for zero wait states
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (haddr[7:0])
            ADDR_CTRL: next_rdata[CTRL_DAD_BIT] = dad_en;
            ADDR_STATUS: next_rdata = status_word;
            ADDR_FAULT_LAST: begin
                next_rdata[15:0] = last_code;
                next_rdata[FL_NONREC] = last_nonrec;
                next_rdata[FL_VALID] = last_valid;
            end
            ADDR_HIST_SEL: next_rdata[3:0] = hist_sel;
            ADDR_HIST_DATA: next_rdata = hist_word;
            ADDR_HIST_COUNT: next_rdata[4:0] = hist_cnt;
            default: next_rdata = 32'h0000_0000;
        endcase
        if (haddr[31:8] != 24'h00_0000) begin
            next_rdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end else if (addr_ok && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

    // Capture write address; data follows in the next cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else if (hready) begin
            wr_pend <= addr_ok && hwrite && (haddr[31:8] == 24'h00_0000);
            wr_addr <= haddr[7:0];
        end
    end

    // Writable fields; the clear bit acts once and is not stored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dad_en <= CTRL_DAD_RESET;
            hist_sel <= HIST_SEL_RESET;
            rec_clear <= 1'b0;
        end else begin
            rec_clear <= 1'b0;
            if (wr_pend && wr_addr == ADDR_CTRL) begin
                dad_en <= hwdata[CTRL_DAD_BIT];
                rec_clear <= hwdata[CTRL_RCLR_BIT];
            end
            if (wr_pend && wr_addr == ADDR_HIST_SEL) begin
                hist_sel <= hwdata[3:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_nonrec_red: assert property (nonrec_fault |=> fault_red [*3])
        else $error("non-recoverable fault lamp not steady");
    a_fault_dark: assert property (!rec_fault && !nonrec_fault |=> !fault_red)
        else $error("fault lamp lit without a fault");
    a_run_steady: assert property (run_mode && !restore_busy |=> run_green)
        else $error("run lamp not steady in run mode");
    a_run_rate: assert property ($changed(run_phase) |->
        $past(run_cnt) == 32'(RUN_HALF - 1))
        else $error("run flash off its half period");
    a_ser_quiet: assert property (!ser_tx_busy |=> !ser_lamp)
        else $error("serial lamp lit without transmit");
    a_force_lamp: assert property (force_any ##1 !force_any |=>
        !force_amber)
        else $error("force lamp kept after forces removed");
    a_card_dark: assert property (!card_present ##1 !card_present |=>
        !card_lamp)
        else $error("card lamp lit with no card");
    a_card_idle: assert property (card_present && card_init_done &&
        !card_access && !card_rw_fail && !card_cfg_error &&
        !card_cfg_read_fail && !card_medium_bad && !card_fs_bad
        |=> ##1 card_lamp)
        else $error("card lamp not steady when idle");
    a_net_dark: assert property (!eth_link ##1 !eth_link |=> !net_green)
        else $error("network lamp lit without link");
    a_net_steady: assert property (eth_link && ip_valid && !ip_duplicate
        |=> net_green)
        else $error("network lamp not steady when operational");
    a_out_lamp: assert property (out_lamp == $past(out_state))
        else $error("output lamp disagrees with output");
    a_hist_bound: assert property (fault_event && fault_nonrec |=>
        hist_cnt <= 5'(HIST_DEPTH) && hist_cnt != 5'h00)
        else $error("fault history count out of range");
    a_blink_rate: assert property ($changed(blink_phase) |->
        $past(blink_cnt) == 32'(BLINK_HALF - 1))
        else $error("blink off its half period");

    c_nonrec: cover property (fault_event && fault_nonrec ##1 fault_red);
    c_net_flash: cover property (eth_link && !ip_valid ##2 net_green);
    c_card_oper: cover property (card_state == CARD_OPER ##1 card_lamp);
    c_service: cover property (port_rx_req[0] ##[1:20] port_service[0]);
endmodule

`default_nettype wire

// ==== verif/sdind_lamp_panel.sv ====
// Purpose: Front-panel lamp model that counts lit cycles per lamp.
// Assumes: Lamps are high when lit, sampled on rising hclk.
// Notes:   Counting lit edges tells steady, flashing and dark apart.
`timescale 1ns/1ps
`default_nettype none
module sdind_lamp_panel (
    input wire logic hclk, // System clock
    input wire logic clear, // Restart the count window
    input wire logic [5:0] lamps, // Status lamps, high = lit
    output logic [5:0][7:0] lit_cnt // Lit cycles per lamp
);
    // Eight bits suffice: windows never exceed a few dozen cycles
    always_ff @(posedge hclk) begin
        for (int k = 0; k < 6; k++) begin
            lit_cnt[k] <= clear ? 8'h00 : lit_cnt[k] + {7'h0, lamps[k]};
        end
    end
endmodule
`default_nettype wire

// ==== verif/status_indicator_driver_bench.sv ====
// Purpose: Self-checking bench for the status indicator driver.
// Assumes: Short flash counts, so every blink window is 32 cycles.
// Notes:   Lamp order: fault, run, serial, force, card, network.
`timescale 1ns/1ps
`default_nettype none
module status_indicator_driver_bench;
import sdind_pkg::*;
logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, clr = 0;
logic [31:0] haddr = 0, hwdata = 0, hrdata, s;
logic [1:0] htrans = 0, port_rx_req = 0, msg_exec = 0, ps, mi;
logic fault_event = 0, fault_nonrec = 0, run_mode = 0, restore_busy = 0;
logic ser_tx_busy = 0, force_any = 0, card_present = 0, card_init_done = 0;
logic card_access = 0, card_rw_fail = 0, eth_link = 0, ip_valid = 0;
logic ip_duplicate = 0, scan_tick = 0, scan_active = 0, hresp;
logic [3:0] cbad = 0;
logic [15:0] fault_code = 0;
logic [11:0] in_term = 0, in_lamp;
logic [7:0] out_state = 0, out_lamp;
logic [5:0] lamps;
logic [5:0][7:0] cnt;
wire hready;
int errors = 0, comparisons = 0, cycles = 0;
sdind_top #(.RUN_HALF(8), .BLINK_HALF(4)) i_dut (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .in_term(in_term),
    .out_state(out_state), .fault_event(fault_event),
    .fault_nonrec(fault_nonrec), .fault_code(fault_code),
    .run_mode(run_mode), .restore_busy(restore_busy),
    .ser_tx_busy(ser_tx_busy), .force_any(force_any),
    .card_present(card_present), .card_medium_bad(cbad[0]),
    .card_fs_bad(cbad[1]), .card_rw_fail(card_rw_fail),
    .card_cfg_read_fail(cbad[2]), .card_cfg_error(cbad[3]),
    .card_init_done(card_init_done), .card_access(card_access),
    .eth_link(eth_link), .ip_valid(ip_valid), .ip_duplicate(ip_duplicate),
    .scan_tick(scan_tick), .scan_active(scan_active),
    .port_rx_req(port_rx_req), .msg_exec(msg_exec), .port_service(ps),
    .msg_issue(mi), .in_lamp(in_lamp), .out_lamp(out_lamp),
    .fault_red(lamps[0]), .run_green(lamps[1]), .ser_lamp(lamps[2]),
    .force_amber(lamps[3]), .card_lamp(lamps[4]), .net_green(lamps[5]));
sdind_lamp_panel i_panel (.hclk(hclk), .clear(clr), .lamps(lamps),
    .lit_cnt(cnt));
// ------------------------------------------------------------
// Clock, timeout and shared tasks
// ------------------------------------------------------------
initial begin
    forever #2.5 hclk = ~hclk;
end
// Whole run is well under a thousand cycles; a hang is cut short
always @(posedge hclk) begin
    cycles++;
    if (cycles == 3000) begin
        errors++;
        tally_and_finish();
    end
end
task automatic tally_and_finish();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
endtask
task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
        errors++;
        $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
endtask
// One single transfer; holds each phase until hready is seen high
task automatic ahb(input logic wr, input logic [7:0] a,
                   input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
endtask
task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
endtask
task automatic rd(input logic [7:0] a, input logic [31:0] m,
                  input logic [31:0] e);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    check(q & m, e);
    check({31'h0, hresp}, {31'h0, HRESP_OKAY});
endtask
task automatic step();
    repeat (4) @(posedge hclk);
endtask
// Lit-cycle counts over 32 cycles: 32 steady, 16 flashing, 0 dark
task automatic win(input logic [5:0][7:0] e);
    clr <= 1'b1;
    @(posedge hclk);
    clr <= 1'b0;
    repeat (32) @(posedge hclk);
    #1;
    for (int k = 0; k < 6; k++) check({24'h0, cnt[k]}, {24'h0, e[k]});
    @(posedge hclk);
endtask
// Pulse tally: nibble 0/1 service ports, nibble 2/3 master issues
// Samples just after the current edge first, so a one-cycle pulse
// launched at that edge is not missed
task automatic watch(input int n);
    s = 0;
    repeat (n) begin
        #1;
        s += 32'(ps[0]) + 32'(ps[1]) * 16 + 32'(mi[0]) * 256 + 32'(mi[1]) * 4096;
        @(posedge hclk);
    end
endtask
task automatic fault(input logic nr, input logic [15:0] c);
    @(posedge hclk);
    fault_event <= 1'b1;
    fault_nonrec <= nr;
    fault_code <= c;
    @(posedge hclk);
    fault_event <= 1'b0;
endtask
// ------------------------------------------------------------
// Main sequence
// ------------------------------------------------------------
initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rd(ADDR_CTRL, '1, 32'h0);
    in_term <= 12'hA5C; out_state <= 8'h3C; force_any <= 1; run_mode <= 1;
    eth_link <= 1; ip_valid <= 1; card_present <= 1; card_init_done <= 1;
    step();
    check({20'h0, in_lamp}, 32'hA5C);
    check({24'h0, out_lamp}, 32'h3C);
    win({8'd32, 8'd32, 8'd32, 8'd0, 8'd32, 8'd0});
    force_any <= 0; eth_link <= 0; card_present <= 0; run_mode <= 0;
    step();
    win({8'd0, 8'd0, 8'd0, 8'd0, 8'd16, 8'd0});
    ser_tx_busy <= 1; eth_link <= 1; ip_valid <= 0; card_present <= 1;
    card_access <= 1;
    step();
    win({8'd16, 8'd16, 8'd0, 8'd16, 8'd16, 8'd0});
    ser_tx_busy <= 0; run_mode <= 1; restore_busy <= 1; card_access <= 0;
    ip_valid <= 1; ip_duplicate <= 1;
    step();
    win({8'd32, 8'd32, 8'd0, 8'd0, 8'd16, 8'd0});
    wr(ADDR_CTRL, 32'h1);
    rd(ADDR_CTRL, '1, 32'h1);
    // Each bad-card condition in turn: lamp dark, state uninit or error
    for (int i = 0; i < 4; i++) begin
        cbad <= 4'h1 << i;
        step();
        rd(ADDR_STATUS, 32'hD0, (i < 2) ? 32'h0 : 32'h40);
    end
    cbad <= 4'h0; card_rw_fail <= 1; restore_busy <= 0;
    step();
    win({8'd16, 8'd0, 8'd0, 8'd0, 8'd32, 8'd0});
    fault(1'b0, 16'h1234);
    step();
    win({8'd16, 8'd0, 8'd0, 8'd0, 8'd32, 8'd16});
    rd(ADDR_FAULT_LAST, '1, 32'h21234);
    wr(ADDR_CTRL, 32'h3);
    step();
    check({31'h0, lamps[0]}, 32'h0);
    for (int i = 0; i < 11; i++) fault(1'b1, 16'h0100 + 16'(i));
    step();
    check({31'h0, lamps[0]}, 32'h1);
    rd(ADDR_HIST_COUNT, '1, 32'd10);
    rd(ADDR_HIST_DATA, 32'hFFFF, 32'h010A);
    wr(ADDR_HIST_SEL, 32'h9);
    rd(ADDR_HIST_DATA, 32'hFFFF, 32'h0101);
    rd(ADDR_FAULT_LAST, '1, 32'h3010A);
    rd(8'h40, '1, 32'h0);
    // Two requests in one scan must merge into a single service
    port_rx_req <= 2'b01; @(posedge hclk); port_rx_req <= 0; @(posedge hclk);
    port_rx_req <= 2'b01; @(posedge hclk); port_rx_req <= 0; @(posedge hclk);
    scan_tick <= 1; @(posedge hclk); scan_tick <= 0;
    watch(4);
    check(s, 32'h1);
    scan_tick <= 1; @(posedge hclk); scan_tick <= 0;
    watch(4);
    check(s, 32'h0);
    scan_active <= 1; msg_exec <= 2'b10; @(posedge hclk); msg_exec <= 0;
    watch(3);
    check(s, 32'h1000);
    scan_active <= 0; msg_exec <= 2'b01; @(posedge hclk); msg_exec <= 0;
    watch(3);
    check(s, 32'h0);
    tally_and_finish();
end
endmodule
`default_nettype wire
